// ===== design/mad_pkg.sv
// Shared constants, types and address helpers for the multiplexed command link
package mad_pkg;

    localparam int BALLS      = 19;
    localparam int LADDR      = 21;
    localparam int BANKS      = 8;
    localparam int BANK_BITS  = 3;

    // Command kinds, as seen by software and by the command decoder
    typedef enum logic [1:0] {
        K_READ    = 2'b00,
        K_WRITE   = 2'b01,
        K_REFRESH = 2'b10,
        K_LOAD    = 2'b11
    } mad_kind_type;

    // Pin encoding {we_n, ref_n} while select is low
    localparam logic [1:0] PIN_LOAD    = 2'h0;
    localparam logic [1:0] PIN_WRITE   = 2'h1;
    localparam logic [1:0] PIN_REFRESH = 2'h2;
    localparam logic [1:0] PIN_READ    = 2'h3;

    // Mode load field positions (ball numbers)
    localparam int MR_CFG0 = 0;
    localparam int MR_CFG1 = 3;
    localparam int MR_CFG2 = 4;
    localparam int MR_MUX  = 5;
    localparam int MR_BL0  = 8;
    localparam int MR_BL1  = 9;
    localparam int MR_DLL  = 3;
    localparam int MR_HIGH = 10;

    localparam logic [1:0] BL2 = 2'h0;
    localparam logic [1:0] BL4 = 2'h1;
    localparam logic [1:0] BL8 = 2'h2;

    localparam logic [2:0] CFG_MIN   = 3'h1;
    localparam logic [2:0] CFG_MAX   = 3'h5;
    localparam logic [2:0] CFG_SHORT = 3'h4;
    // Bank cycle and latencies in multiplexed mode, indexed by configuration
    localparam logic [3:0] BANK_CYCLE_TAB [1:5] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
    localparam logic [3:0] READ_LAT_TAB   [1:5] = '{4'h5, 4'h7, 4'h9, 4'h4, 4'h6};
    localparam logic [3:0] WRITE_LAT_TAB  [1:5] = '{4'h6, 4'h8, 4'hA, 4'h5, 4'h7};

    localparam logic [2:0] CFG_RESET  = 3'h2;
    localparam logic [1:0] BL_RESET   = BL4;

    localparam int CLK_PERIOD_PS          = 5000;
    localparam int MODE_LOAD_RECOVERY_NS  = 30;
    localparam int MODE_LOAD_RECOVERY_CYC =
        (MODE_LOAD_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DUMMY_LOADS  = 2;
    localparam int INIT_NOPS    = 1024;
    localparam int NOPS_PER_REF = INIT_NOPS / BANKS;

    // Balls that carry the address in the first phase
    localparam logic [18:0] P1_MASK = 19'h6_6739;

    // Register map of the controller
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_MODE   = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_ADDR   = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_INIT = 0;
    localparam int CTRL_LOAD = 1;
    localparam int MODE_CFG  = 0;
    localparam int MODE_BL   = 4;
    localparam int MODE_DLL  = 8;
    localparam int CMD_KIND  = 0;
    localparam int CMD_BANK  = 4;
    localparam int ST_DONE   = 0;
    localparam int ST_BUSY   = 1;
    localparam int ST_PEND   = 2;
    localparam int ST_BAD    = 3;

    function automatic logic mad_use_a19(int width, logic [1:0] bl);
        return (width == 18 && bl == BL2) || (width == 9 && bl != BL8);
    endfunction

    function automatic logic mad_use_a20(int width, logic [1:0] bl);
        return width == 9 && bl == BL2;
    endfunction

    function automatic logic [18:0] mad_phase2(logic [20:0] a, logic u19, logic u20);
        logic [18:0] p;
        p     = '0;
        p[3]  = a[1];
        p[4]  = a[2];
        p[8]  = a[6];
        p[9]  = a[7];
        p[13] = a[11];
        p[14] = a[12];
        p[17] = a[16];
        p[18] = a[15];
        p[10] = u19 & a[19];
        p[0]  = u20 & a[20];
        return p;
    endfunction

    function automatic logic [20:0] mad_join(logic [18:0] p1, logic [18:0] p2,
                                             logic u19, logic u20);
        logic [20:0] a;
        a        = {2'h0, p1 & P1_MASK};
        a[1]     = p2[3];
        a[2]     = p2[4];
        a[6]     = p2[8];
        a[7]     = p2[9];
        a[11]    = p2[13];
        a[12]    = p2[14];
        a[16]    = p2[17];
        a[15]    = p2[18];
        a[19]    = u19 & p2[10];
        a[20]    = u20 & p2[0];
        return a;
    endfunction

endpackage

// ===== design/mad_if.sv
// Command and address pins between controller and memory command decoder
interface mad_if;
    logic        cs_n;
    logic        we_n;
    logic        ref_n;
    logic [18:0] addr;
    logic [2:0]  bank;

    modport ctrl (output cs_n, we_n, ref_n, addr, bank);
    modport dram (input cs_n, we_n, ref_n, addr, bank);
endinterface

// ===== design/mad_dram.sv
// Memory-side command decoder for non-multiplexed and multiplexed address modes
module mad_dram
    import mad_pkg::*;
#(
    parameter int WIDTH = 36
) (
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    mad_if.dram                        PINS,
    output logic                       EXEC_VALID,
    output mad_pkg::mad_kind_type      EXEC_KIND,
    output logic [mad_pkg::BANK_BITS-1:0] EXEC_BANK,
    output logic [mad_pkg::LADDR-1:0]  EXEC_ADDR,
    output logic                       MUX_MODE,
    output logic                       DLL_ON,
    output logic [2:0]                 CONFIG,
    output logic [1:0]                 BURST,
    output logic [3:0]                 BANK_CYCLE,
    output logic [3:0]                 READ_LATENCY,
    output logic [3:0]                 WRITE_LATENCY
);
    typedef enum logic {D_CMD = 1'b0, D_SECOND = 1'b1} mad_dstate_type;

    mad_dstate_type state;
    mad_kind_type   hold_kind;
    logic [2:0]     hold_bank;
    logic [18:0]    hold_p1;

    wire          sel       = !PINS.cs_n;
    wire [1:0]    pin_code  = {PINS.we_n, PINS.ref_n};
    wire mad_kind_type pin_kind =
        pin_code == PIN_LOAD    ? K_LOAD :
        pin_code == PIN_WRITE   ? K_WRITE :
        pin_code == PIN_REFRESH ? K_REFRESH : K_READ;
    // After a refresh the second cycle is free, so it may hold a fresh command
    wire          take_new  = sel && (state == D_CMD || hold_kind == K_REFRESH);
    wire          finish    = state == D_SECOND;
    wire          u19       = mad_use_a19(WIDTH, BURST);
    wire          u20       = mad_use_a20(WIDTH, BURST);
    wire [20:0]   joined    = mad_join(hold_p1, PINS.addr, u19, u20);
    // Configuration travels in the first phase, so judge the held copy
    wire [2:0]    new_cfg   = {hold_p1[MR_CFG2], hold_p1[MR_CFG1], hold_p1[MR_CFG0]};
    wire          cfg_ok    = new_cfg >= CFG_MIN && new_cfg <= CFG_MAX;
    wire          mux_load  = finish && hold_kind == K_LOAD;
    wire          flat_cmd  = !MUX_MODE && sel;
    wire [3:0]    lat_trim  = MUX_MODE ? 4'h0 : 4'h1;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state     <= D_CMD;
            hold_kind <= K_READ;
            hold_bank <= '0;
            hold_p1   <= '0;
        end else if (MUX_MODE) begin
            if (take_new) begin
                state     <= D_SECOND;
                hold_kind <= pin_kind;
                hold_bank <= PINS.bank;
                hold_p1   <= PINS.addr;
            end else begin
                state     <= D_CMD;
            end
        end else begin
            state <= D_CMD;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            EXEC_VALID <= 1'b0;
            EXEC_KIND  <= K_READ;
            EXEC_BANK  <= '0;
            EXEC_ADDR  <= '0;
        end else begin
            EXEC_VALID <= finish || flat_cmd;
            if (finish) begin
                EXEC_KIND <= hold_kind;
                EXEC_BANK <= hold_bank;
                // Refresh uses only the bank, so the second cycle's balls are ignored
                EXEC_ADDR <= hold_kind == K_REFRESH ? '0 : joined;
            end else if (flat_cmd) begin
                EXEC_KIND <= pin_kind;
                EXEC_BANK <= PINS.bank;
                EXEC_ADDR <= {2'h0, PINS.addr};
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            MUX_MODE <= 1'b0;
            DLL_ON   <= 1'b1;
            CONFIG   <= CFG_RESET;
            BURST    <= BL_RESET;
        end else if (flat_cmd && pin_kind == K_LOAD && PINS.addr[MR_MUX]) begin
            MUX_MODE <= 1'b1;
        end else if (mux_load && hold_p1[MR_MUX]) begin
            DLL_ON <= !PINS.addr[MR_DLL];
            BURST  <= {hold_p1[MR_BL1], hold_p1[MR_BL0]};
            if (cfg_ok) begin
                CONFIG <= new_cfg;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            BANK_CYCLE    <= BANK_CYCLE_TAB[CFG_RESET];
            READ_LATENCY  <= READ_LAT_TAB[CFG_RESET] - 4'h1;
            WRITE_LATENCY <= WRITE_LAT_TAB[CFG_RESET] - 4'h1;
        end else begin
            BANK_CYCLE    <= BANK_CYCLE_TAB[CONFIG];
            READ_LATENCY  <= READ_LAT_TAB[CONFIG] - lat_trim;
            WRITE_LATENCY <= WRITE_LAT_TAB[CONFIG] - lat_trim;
        end
    end
endmodule

// ===== design/mad_ctrl.sv
// Memory controller end: power-up sequence, mode loads and spaced commands
// Overview of operation
// - Power-up: two dummy loads, then one valid load
// - Dummy loads drive every address ball low
// - Mode loads hold balls ten to eighteen low
// - Flat load with ball five high enters multiplexed mode
// - Wait recovery before the two-cycle multiplexed load
// - Multiplexed load sets balls 0,3,4,5,8,9 as defined
// - Refresh all eight banks among 1024 idle cycles
// - Restart delay loop after clock period change
// - Delay-loop restart bit turns the loop off
// - Address goes out in two phases
// - Second phase carries bits on shared balls
// - Multiplexed mode adds one latency cycle
// - Five configurations set cycle and latencies
// - Never program burst eight in configurations one, four
// - Three-cycle config: write then read needs four
// - Refresh executes on the following rising edge
// - Refresh takes one cycle; next command follows
// - Write after write, same bank, waits bank cycle
// - Write after read, same bank, waits bank cycle
//
// Our own choices: strobed register access and the address map.
module mad_ctrl
    import mad_pkg::*;
#(
    parameter int WIDTH        = 36,
    parameter int RECOVERY_CYC = MODE_LOAD_RECOVERY_CYC,
    parameter int REF_GAP      = NOPS_PER_REF
) (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic [7:0]  REG_ADDRESS,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WRITE,
    input  wire logic        REG_READ,
    output logic [31:0]      REG_RDATA,
    mad_if.ctrl              PINS
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_DUMMY = 4'h1,
        S_ENTER = 4'h2,
        S_WAIT  = 4'h3,
        S_MUX1  = 4'h4,
        S_MUX2  = 4'h5,
        S_REF   = 4'h6,
        S_RUN   = 4'h7,
        S_PH2   = 4'h8
    } mad_cstate_type;

    mad_cstate_type state;
    mad_cstate_type after_wait;
    logic [10:0]    wait_cnt;
    logic [2:0]     ref_bank;
    logic           init_done;
    logic [2:0]     mode_cfg;
    logic [1:0]     mode_bl;
    logic           mode_dll;
    logic           load_pend;
    logic           cmd_pend;
    logic           bad_mode;
    mad_kind_type   cmd_kind;
    logic [2:0]     cmd_bank;
    logic [20:0]    cmd_addr;
    logic [3:0]     bank_cnt [BANKS];

    // Register port decode
    wire wr_ctrl   = REG_WRITE && REG_ADDRESS == REG_CTRL;
    wire wr_mode   = REG_WRITE && REG_ADDRESS == REG_MODE;
    wire wr_cmd    = REG_WRITE && REG_ADDRESS == REG_CMD;
    wire wr_addr   = REG_WRITE && REG_ADDRESS == REG_ADDR;
    wire busy      = state != S_IDLE && state != S_RUN;
    wire [31:0] status = {28'h0, bad_mode, cmd_pend, busy, init_done};
    wire [31:0] rd_mux =
        REG_ADDRESS == REG_MODE   ? {23'h0, mode_dll, 2'h0, mode_bl, 1'b0, mode_cfg} :
        REG_ADDRESS == REG_CMD    ? {25'h0, cmd_bank, 2'h0, cmd_kind} :
        REG_ADDRESS == REG_ADDR   ? {11'h0, cmd_addr} :
        REG_ADDRESS == REG_STATUS ? status : 32'h0;
    wire [2:0] new_cfg = REG_WDATA[MODE_CFG +: 3];
    wire [1:0] new_bl  = REG_WDATA[MODE_BL +: 2];
    wire mode_legal = new_cfg >= CFG_MIN && new_cfg <= CFG_MAX && new_bl != 2'h3 &&
                      !(new_bl == BL8 && (new_cfg == CFG_MIN || new_cfg == CFG_SHORT));

    // Issue decision and pin contents
    wire        bank_free = bank_cnt[cmd_bank] == 4'h0;
    wire        issue     = state == S_RUN && !load_pend && cmd_pend && bank_free;
    wire        u19       = mad_use_a19(WIDTH, mode_bl);
    wire        u20       = mad_use_a20(WIDTH, mode_bl);
    wire [18:0] ph1       = cmd_addr[18:0] & P1_MASK;
    wire [18:0] ph2       = mad_phase2(cmd_addr, u19, u20);
    wire [3:0]  bank_cycle_time       = BANK_CYCLE_TAB[mode_cfg];
    wire [1:0]  cmd_pins  = cmd_kind == K_WRITE   ? PIN_WRITE :
                            cmd_kind == K_REFRESH ? PIN_REFRESH : PIN_READ;
    wire        ref_issue = state == S_REF;
    wire        do_load   = (wr_ctrl && REG_WDATA[CTRL_LOAD]) || (wr_mode && mode_legal);

    logic       next_cs_n;
    logic [1:0] next_code;
    logic [18:0] next_addr;
    logic [2:0] next_bank;

    always_comb begin
        next_cs_n = 1'b1;
        next_code = PIN_READ;
        next_addr = '0;
        next_bank = '0;
        unique case (state)
            S_DUMMY: begin
                next_cs_n = 1'b0;
                next_code = PIN_LOAD;
            end
            S_ENTER: begin
                next_cs_n = 1'b0;
                next_code = PIN_LOAD;
                next_addr[MR_MUX] = 1'b1;
            end
            S_MUX1: begin
                next_cs_n = 1'b0;
                next_code = PIN_LOAD;
                next_addr[MR_CFG0] = mode_cfg[0];
                next_addr[MR_CFG1] = mode_cfg[1];
                next_addr[MR_CFG2] = mode_cfg[2];
                next_addr[MR_MUX]  = 1'b1;
                next_addr[MR_BL0]  = mode_bl[0];
                next_addr[MR_BL1]  = mode_bl[1];
            end
            S_MUX2: begin
                next_addr[MR_DLL] = mode_dll;
            end
            S_REF: begin
                next_cs_n = 1'b0;
                next_code = PIN_REFRESH;
                next_bank = ref_bank;
            end
            S_RUN: begin
                if (issue) begin
                    next_cs_n = 1'b0;
                    next_code = cmd_pins;
                    next_bank = cmd_bank;
                    next_addr = cmd_kind == K_REFRESH ? 19'h0 : ph1;
                end
            end
            S_PH2: begin
                next_addr = ph2;
            end
            S_IDLE, S_WAIT: begin
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            PINS.cs_n  <= 1'b1;
            PINS.we_n  <= 1'b1;
            PINS.ref_n <= 1'b1;
            PINS.addr  <= '0;
            PINS.bank  <= '0;
            REG_RDATA  <= '0;
        end else begin
            PINS.cs_n  <= next_cs_n;
            {PINS.we_n, PINS.ref_n} <= next_code;
            PINS.addr  <= next_addr;
            PINS.bank  <= next_bank;
            REG_RDATA  <= REG_READ ? rd_mux : 32'h0;
        end
    end

    // Per-bank bank-cycle counters
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        wire hit_cmd = issue && cmd_bank == 3'(b);
        wire hit_ref = ref_issue && ref_bank == 3'(b);
        // Writes in the three-cycle configuration hold the bank one cycle longer
        wire [3:0] extra = (cmd_kind == K_WRITE && bank_cycle_time == 4'h3) ? 4'h1 : 4'h0;
        always_ff @(posedge MCLK) begin
            if (RST) begin
                bank_cnt[b] <= 4'h0;
            end else if (hit_cmd) begin
                bank_cnt[b] <= bank_cycle_time - 4'h1 + extra;
            end else if (hit_ref) begin
                bank_cnt[b] <= bank_cycle_time - 4'h1;
            end else if (bank_cnt[b] != 4'h0) begin
                bank_cnt[b] <= bank_cnt[b] - 4'h1;
            end
        end
    end

    // Software-visible settings and pending requests
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode_cfg  <= CFG_RESET;
            mode_bl   <= BL_RESET;
            mode_dll  <= 1'b0;
            bad_mode  <= 1'b0;
            cmd_kind  <= K_READ;
            cmd_bank  <= '0;
            cmd_addr  <= '0;
            cmd_pend  <= 1'b0;
            load_pend <= 1'b0;
        end else begin
            if (wr_mode) begin
                bad_mode <= !mode_legal;
                if (mode_legal) begin
                    mode_cfg <= new_cfg;
                    mode_bl  <= new_bl;
                    mode_dll <= REG_WDATA[MODE_DLL];
                end
            end
            if (wr_addr && !cmd_pend) begin
                cmd_addr <= REG_WDATA[20:0];
            end
            if (wr_cmd && !cmd_pend && init_done && REG_WDATA[1:0] != K_LOAD) begin
                cmd_kind <= mad_kind_type'(REG_WDATA[CMD_KIND +: 2]);
                cmd_bank <= REG_WDATA[CMD_BANK +: 3];
                cmd_pend <= 1'b1;
            end else if (issue) begin
                cmd_pend <= 1'b0;
            end
            if (do_load && init_done) begin
                load_pend <= 1'b1;
            end else if (state == S_MUX1) begin
                load_pend <= 1'b0;
            end
        end
    end

    // Sequencer
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state      <= S_IDLE;
            after_wait <= S_IDLE;
            wait_cnt   <= '0;
            ref_bank   <= '0;
            init_done  <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (wr_ctrl && REG_WDATA[CTRL_INIT]) begin
                        state    <= S_DUMMY;
                        wait_cnt <= 11'(DUMMY_LOADS - 1);
                    end
                end
                S_DUMMY: begin
                    if (wait_cnt == '0) begin
                        state <= S_ENTER;
                    end else begin
                        wait_cnt <= wait_cnt - 11'h1;
                    end
                end
                S_ENTER: begin
                    state      <= S_WAIT;
                    wait_cnt   <= 11'(RECOVERY_CYC - 1);
                    after_wait <= S_MUX1;
                end
                S_WAIT: begin
                    if (wait_cnt == '0) begin
                        state <= after_wait;
                    end else begin
                        wait_cnt <= wait_cnt - 11'h1;
                    end
                end
                S_MUX1: begin
                    state <= S_MUX2;
                end
                S_MUX2: begin
                    state      <= S_WAIT;
                    wait_cnt   <= 11'(RECOVERY_CYC - 1);
                    after_wait <= init_done ? S_RUN : S_REF;
                end
                S_REF: begin
                    state      <= S_WAIT;
                    wait_cnt   <= 11'(REF_GAP - 1);
                    ref_bank   <= ref_bank + 3'h1;
                    after_wait <= ref_bank == 3'(BANKS - 1) ? S_RUN : S_REF;
                    init_done  <= ref_bank == 3'(BANKS - 1);
                end
                S_RUN: begin
                    if (load_pend) begin
                        state <= S_MUX1;
                    end else if (issue && cmd_kind != K_REFRESH) begin
                        state <= S_PH2;
                    end
                end
                S_PH2: begin
                    state <= S_RUN;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== bench/mad_asserts.sv
// Pin-level checks of the multiplexed command link
module mad_asserts (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        cs_n,
    input wire logic        we_n,
    input wire logic        ref_n,
    input wire logic [18:0] addr,
    input wire logic [2:0]  bank
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       mux;
    logic [1:0] nld;
    logic [3:0] age [8];
    logic [7:0] wlast;
    wire logic  ld  = !cs_n && !we_n && !ref_n;
    wire logic  cmd = mux && !cs_n && !ld;
    wire logic  rfr = !cs_n && we_n && !ref_n;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Per-bank cycles since the last first-phase command
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mux <= 1'b0;
            nld <= 2'h0;
            wlast <= 8'h00;
            for (int i = 0; i < 8; i++)
                age[i] <= 4'hF;
        end else begin
            mux <= mux | (ld & addr[5]);
            nld <= nld + {1'b0, ld && nld != 2'h3};
            for (int i = 0; i < 8; i++)
                age[i] <= (cmd && bank == i[2:0]) ? 4'h0 : age[i] + {3'h0, age[i] != 4'hF};
            if (cmd)
                wlast[bank] <= !we_n;
        end
    end
    init_loads_a: assert property (!cs_n && nld < 2'h3 |-> ld)
        else $error("power-up command is not a mode load");
    dummy_zero_a: assert property (ld && nld < 2'h2 |-> addr == 19'h0)
        else $error("dummy load address not low");
    high_zero_a: assert property (ld |-> addr[18:10] == 9'h0)
        else $error("mode load high balls set");
    enter_mux_a: assert property (ld && nld == 2'h2 |-> addr[5])
        else $error("valid load without mux select");
    recover_a: assert property (ld && !mux && addr[5] |=> cs_n [*2])
        else $error("command inside mode load recovery");
    mux_load_a: assert property (ld && mux |-> addr[5])
        else $error("mux load without ball five");
    phase_two_a: assert property (cmd && !rfr |=> cs_n && (addr & ~19'h6_6318) == 19'h0)
        else $error("bad second address phase");
    bank_gap_a: assert property (cmd |-> age[bank] >= 4'h2)
        else $error("same bank command too soon");
    write_gap_a: assert property (cmd && wlast[bank] |-> age[bank] >= 4'h3)
        else $error("command too soon after write");
    cover property (rfr && mux ##1 !cs_n);
endmodule

// ===== bench/tb_muxed_address_cmd_interface.sv
// Self-checking bench joining controller and command decoder
module tb_muxed_address_cmd_interface;
    timeunit 1ns;
    timeprecision 100ps;
    import mad_pkg::*;
    typedef struct packed {logic [1:0] kind; logic [2:0] bank; logic [20:0] addr; logic full;}
        mad_note_type;
    logic         mclk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic         exec_valid, mux_mode, dll_on;
    logic [7:0]   reg_address = 8'h00;
    logic [31:0]  reg_wdata = 32'h0000_0000, reg_rdata, seed = 32'hbe9c_267e, s, st;
    logic [2:0]   exec_bank, cfg_o, m3 = 3'h0;
    logic [20:0]  exec_addr;
    logic [1:0]   burst, c2 = 2'h0;
    logic [3:0]   bcyc, rlat, wlat;
    mad_kind_type exec_kind;
    mad_note_type notes [$];
    mad_note_type n;
    int           errors = 0, checked = 0, cycles = 0, gap = 0;
    int           last [8] = '{default: -99};
    int           rc [5] = '{4, 6, 8, 3, 5};
    mad_if pins ();
    mad_ctrl #(.WIDTH(36), .RECOVERY_CYC(2), .REF_GAP(4)) i_mad_ctrl (.MCLK(mclk), .RST(rst),
        .REG_ADDRESS(reg_address), .REG_WDATA(reg_wdata), .REG_WRITE(reg_write),
        .REG_READ(reg_read), .REG_RDATA(reg_rdata), .PINS(pins));
    mad_dram #(.WIDTH(36)) i_mad_dram (.MCLK(mclk), .RST(rst), .PINS(pins),
        .EXEC_VALID(exec_valid), .EXEC_KIND(exec_kind), .EXEC_BANK(exec_bank),
        .EXEC_ADDR(exec_addr), .MUX_MODE(mux_mode), .DLL_ON(dll_on), .CONFIG(cfg_o),
        .BURST(burst), .BANK_CYCLE(bcyc), .READ_LATENCY(rlat), .WRITE_LATENCY(wlat));
    mad_asserts i_mad_asserts (.MCLK(mclk), .RST(rst), .cs_n(pins.cs_n), .we_n(pins.we_n),
        .ref_n(pins.ref_n), .addr(pins.addr), .bank(pins.bank));
    always #2.5 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic results();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_address <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_address <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 st = reg_rdata;
    endtask
    // Polls status until the masked bits reach the wanted value
    task automatic idle(input logic [31:0] m, input logic [31:0] v);
        repeat (400) begin
            rd(REG_STATUS);
            if ((st & m) == v) break;
        end
        chk(st & m, v);
    endtask
    task automatic mode(input logic [31:0] v);
        wr(REG_MODE, v);
        notes.push_back('{K_LOAD, 3'h0, 21'h0, 1'b0});
        idle(32'h6, 32'h0);
        repeat (4) @(posedge mclk);
    endtask
    task automatic cmd(input logic [1:0] k, input logic [2:0] b, input logic [20:0] a);
        wr(REG_ADDR, {11'h0, a});
        wr(REG_CMD, {25'h0, b, 2'h0, k});
        notes.push_back('{k, b, (k == K_REFRESH) ? 21'h0 : a, 1'b1});
        idle(32'h4, 32'h0);
    endtask
    // Result watcher: each executed command takes the oldest note
    always @(posedge mclk) begin
        m3 <= {m3[1:0], mux_mode};
        c2 <= {c2[0], ~pins.cs_n};
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
        if (exec_valid === 1'b1) begin
            if (&m3) chk(c2[1], 1'b1);
            if (notes.size() == 0) chk(1'b1, 1'b0);
            else begin
                n = notes.pop_front();
                chk(exec_kind, n.kind);
                if (n.full) begin
                    chk({exec_bank, exec_addr}, {n.bank, n.addr});
                    chk(cycles - last[exec_bank] >= gap, 1'b1);
                    last[exec_bank] = cycles;
                end
            end
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h14);
        chk(st, 32'h0);
        chk({mux_mode, bcyc, rlat, wlat}, {1'b0, 12'h667});
        wr(REG_ADDR, 32'h1);
        wr(REG_CMD, 32'h1);
        wr(REG_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) notes.push_back('{K_LOAD, 3'h0, 21'h0, 1'b0});
        for (int i = 0; i < 8; i++) notes.push_back('{K_REFRESH, i[2:0], 21'h0, 1'b1});
        idle(32'h1, 32'h1);
        chk({mux_mode, cfg_o, burst, bcyc, rlat, wlat}, {1'b1, 3'h2, 2'h1, 12'h678});
        mode(32'h0000_0112);
        chk(dll_on, 1'b0);
        mode(32'h0000_0012);
        chk(dll_on, 1'b1);
        wr(REG_MODE, 32'h0000_0021);
        rd(REG_STATUS);
        chk({st[3], cfg_o}, {1'b1, 3'h2});
        for (int c = 1; c <= 5; c++) begin
            mode(c);
            chk({cfg_o, burst, bcyc, rlat, wlat}, {c[2:0], 2'h0, 4'(rc[c-1]),
                4'(rc[c-1] + 1), 4'(rc[c-1] + 2)});
        end
        mode(32'h3);
        gap = 8;
        cmd(K_WRITE, 3'h2, 21'h1_2345);
        cmd(K_READ, 3'h2, 21'h0_0F0F);
        cmd(K_WRITE, 3'h2, 21'h6_1234);
        gap = 3;
        mode(32'h4);
        cmd(K_WRITE, 3'h1, 21'h0_5A5A);
        cmd(K_READ, 3'h1, 21'h7_FFFF);
        cmd(K_WRITE, 3'h1, 21'h2_3456);
        cmd(K_WRITE, 3'h1, 21'h0_0001);
        for (int i = 0; i < 24; i++) begin
            s = rnd();
            cmd(s[1:0] == 2'h3 ? K_REFRESH : s[1:0], s[4:2], {2'h0, s[31:13]});
        end
        repeat (10) @(posedge mclk);
        chk(notes.size(), 0);
        results();
    end
endmodule
